// >>> sapc_pkg.sv
// Behaviour
// - standby input high holds deep sleep state
// - nap input high enters very low power
// - convert strobe fall starts conversion when idle and powered
// - sampler switches to hold on strobe fall
// - reset low aborts conversion, resets state machine
// - reset held low ignores conversion requests
// - saturate_enable saturates over and under range results
// - chip select, read and write low drive bus
// - offset captured on write pulse falling edge
// - busy low from strobe fall through conversion
// - mode 2 busy rises on the same edge as the output load
// - mode 1 busy rises early, load next strobe
// - bidirectional 14-bit bus, msb on top line
// - fifteenth bit carries overrange flag
// - nap powers down all but reference
// - sampler returns to track at conversion end
`default_nettype none
package sapc_pkg;
    // ------------------------------------------------------------
    // widths and timing
    // ------------------------------------------------------------
    localparam int DATA_W = 14;
    localparam int CLK_PERIOD_NS = 8;
    localparam int CONV_TIME_NS = 300;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int NAP_SETTLE_NS = 100;
    localparam int NAP_SETTLE_CYCLES = (NAP_SETTLE_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // mode select code: {hi,lo}; 2'b10 picks mode 2, others mode 1
    localparam logic [1:0] SEL_INTERFACE_SELECT_HI = 2'h2;
    localparam logic [DATA_W-1:0] OFFSET_RST = 14'h0000;
    localparam logic [DATA_W-1:0] ALL_ONES = 14'h3FFF;
    localparam logic [DATA_W-1:0] ALL_ZEROS = 14'h0000;

    typedef enum logic [1:0] {
        SAPC_IDLE = 2'b00,
        SAPC_CONV = 2'b01,
        SAPC_LOAD = 2'b11
    } sapc_state_t;
endpackage
`default_nettype wire

// >>> sapc_edge.sv
`timescale 1ns/10ps
`default_nettype none
// falling/rising edge detector on a synchronous input
module sapc_edge (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_sig,
    output logic o_fall,
    output logic o_rise
);
    logic prev_ff;

    // the previous level follows the pin through reset as well, so a
    // level already held at release is never taken for an edge
    always_ff @(posedge i_clk) begin
        prev_ff <= i_sig;
    end

    // no edge is reported while reset is low
    assign o_fall = i_rst_n & prev_ff & ~i_sig;
    assign o_rise = i_rst_n & ~prev_ff & i_sig;
endmodule
`default_nettype wire

// >>> sapc_result.sv
`timescale 1ns/10ps
`default_nettype none
// offset removal and clipping of a raw conversion code
module sapc_result
    import sapc_pkg::*;
(
    input wire logic [DATA_W-1:0] i_raw,
    input wire logic [DATA_W-1:0] i_offset,
    input wire logic i_saturate_enable,
    output logic [DATA_W-1:0] o_data,
    output logic o_ovr
);
    // offset is two's complement; one guard bit each side
    wire logic signed [DATA_W+1:0] sum =
        $signed({2'b00, i_raw}) + $signed({{2{i_offset[DATA_W-1]}}, i_offset});
    wire logic over_hi = ~sum[DATA_W+1] & sum[DATA_W];
    wire logic under_lo = sum[DATA_W+1];

    // saturate_enable to the rails, else wrap and flag overrange
    assign o_data = (i_saturate_enable && over_hi) ? ALL_ONES :
                    (i_saturate_enable && under_lo) ? ALL_ZEROS :
                    sum[DATA_W-1:0];
    assign o_ovr = (over_hi | under_lo) & ~i_saturate_enable;
endmodule
`default_nettype wire

// >>> sapc_top.sv
`timescale 1ns/10ps
`default_nettype none
// control and parallel host interface of the converter
module sapc_top
    import sapc_pkg::*;
#(
    parameter int CONV_CNT = CONV_CYCLES
) (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_DEEP_SLEEP_IN,
    input wire logic I_NAP,
    input wire logic I_CONVERT_STROBE_N,
    input wire logic I_INTERFACE_SELECT_LO,
    input wire logic I_INTERFACE_SELECT_HI,
    input wire logic I_SATURATE_ENABLE,
    input wire logic I_CS_N,
    input wire logic I_RD_N,
    input wire logic I_WRITE,
    input wire logic [DATA_W-1:0] I_RESULT_BUS,
    input wire logic [DATA_W-1:0] I_SAR_CODE,
    output logic [DATA_W-1:0] O_RESULT_BUS,
    output logic O_RESULT_BUS_OE,
    output logic O_OVERRANGE_BIT,
    output logic O_OVERRANGE_BIT_OE,
    output logic O_BUSY_N,
    output logic O_HOLD,
    output logic O_NAP_PD,
    output logic O_STANDBY_PD
);
    // the count must fit the counter; zero would never end a conversion
    if (CONV_CNT < 1 || CONV_CNT > 4096) begin : g_bad_cnt
        $error("CONV_CNT out of range");
    end

    localparam int CW = $clog2(CONV_CNT + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(CONV_CNT - 1);

    // ------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------
    logic cnv_fall;
    logic wr_fall;

    sapc_edge u_cnv_edge (
        .i_clk(I_CLK),
        .i_rst_n(I_RST_N),
        .i_sig(I_CONVERT_STROBE_N),
        .o_fall(cnv_fall),
        .o_rise()
    );

    sapc_edge u_wr_edge (
        .i_clk(I_CLK),
        .i_rst_n(I_RST_N),
        .i_sig(I_WRITE),
        .o_fall(wr_fall),
        .o_rise()
    );

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    sapc_state_t state_ff, nxt_state;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic [DATA_W-1:0] offset_ff;
    logic [DATA_W-1:0] sar_ff;
    logic [DATA_W-1:0] out_ff;
    logic ovr_ff;
    logic pend_ff;
    logic busy_n_ff;
    logic hold_ff;
    logic oe_ff;
    logic nap_ff;
    logic deep_sleep_in_ff;
    logic [DATA_W-1:0] proc_data;
    logic proc_ovr;

    wire logic interface_select_hi = {I_INTERFACE_SELECT_HI, I_INTERFACE_SELECT_LO}
        == SEL_INTERFACE_SELECT_HI;
    // powered-down core does not start a conversion
    wire logic powered = ~I_NAP & ~I_DEEP_SLEEP_IN;
    wire logic start = cnv_fall & powered;
    wire logic take = start & (state_ff == SAPC_IDLE);
    wire logic conv_end = (state_ff == SAPC_CONV) && (cnt_ff == CNT_LAST);
    // mode 1 moves the pending result out at the next strobe
    wire logic late_load = start & pend_ff & ~interface_select_hi;
    wire logic early_load = state_ff == SAPC_LOAD;
    // cs may be tied low; then rd low with write low gates the bus
    wire logic rd_act = ~I_CS_N & ~I_RD_N & ~I_WRITE;
    wire logic wr_take = wr_fall & ~I_CS_N;

    sapc_result u_result (
        .i_raw(sar_ff),
        .i_offset(offset_ff),
        .i_saturate_enable(I_SATURATE_ENABLE),
        .o_data(proc_data),
        .o_ovr(proc_ovr)
    );

    // ------------------------------------------------------------
    // conversion state machine
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        unique case (state_ff)
            SAPC_IDLE: begin
                if (start) begin
                    nxt_state = SAPC_CONV;
                    nxt_cnt = '0;
                end
            end
            SAPC_CONV: begin
                nxt_cnt = cnt_ff + CW'(1);
                if (conv_end) begin
                    nxt_state = interface_select_hi ? SAPC_LOAD : SAPC_IDLE;
                end
            end
            SAPC_LOAD: begin
                nxt_state = SAPC_IDLE;
            end
            default: begin
                nxt_state = SAPC_IDLE;
            end
        endcase
    end

    // reset aborts and holds the machine idle
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            state_ff <= SAPC_IDLE;
            cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // busy falls on a taken strobe and rises as the mode asks
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            busy_n_ff <= 1'b1;
        end else if (take) begin
            busy_n_ff <= 1'b0;
        end else if (conv_end) begin
            busy_n_ff <= interface_select_hi ? 1'b0 : 1'b1;
        end else if (early_load) begin
            busy_n_ff <= 1'b1;
        end
    end

    // sampler holds from the taken strobe up to the last count
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            hold_ff <= 1'b0;
        end else if (take) begin
            hold_ff <= 1'b1;
        end else if (conv_end) begin
            hold_ff <= 1'b0;
        end
    end

    // raw code and pending flag; a set at conversion end wins over a
    // clear, so a mode 1 result is never lost to a same-cycle load
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            sar_ff <= '0;
            pend_ff <= 1'b0;
        end else begin
            if (conv_end) begin
                sar_ff <= I_SAR_CODE;
            end
            if (conv_end && !interface_select_hi) begin
                pend_ff <= 1'b1;
            end else if (late_load || early_load) begin
                pend_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // output register and offset
    // ------------------------------------------------------------
    // output register, offset register and bus drive
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            out_ff <= '0;
            ovr_ff <= 1'b0;
            offset_ff <= OFFSET_RST;
            oe_ff <= 1'b0;
        end else begin
            if (late_load || early_load) begin
                out_ff <= proc_data;
                ovr_ff <= proc_ovr;
            end
            if (wr_take) begin
                offset_ff <= I_RESULT_BUS;
            end
            oe_ff <= rd_act;
        end
    end

    // ------------------------------------------------------------
    // power state
    // ------------------------------------------------------------
    // power state pins; nap keeps only the reference alive
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            nap_ff <= 1'b0;
            deep_sleep_in_ff <= 1'b0;
        end else begin
            nap_ff <= I_NAP;
            deep_sleep_in_ff <= I_DEEP_SLEEP_IN;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // every top output is a flop, so the host sees no decode glitch
    assign O_RESULT_BUS = out_ff;
    assign O_RESULT_BUS_OE = oe_ff;
    assign O_OVERRANGE_BIT = ovr_ff;
    assign O_OVERRANGE_BIT_OE = oe_ff;
    assign O_BUSY_N = busy_n_ff;
    assign O_HOLD = hold_ff;
    assign O_NAP_PD = nap_ff;
    assign O_STANDBY_PD = deep_sleep_in_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    busy_on_start_a: assert property (
        start && state_ff == SAPC_IDLE |=> !O_BUSY_N && O_HOLD)
        else $error("busy or hold missing after strobe");
    track_at_end_a: assert property (conv_end |=> !O_HOLD)
        else $error("sampler not back to track");
    interface_select_lo_busy_a: assert property (conv_end && !interface_select_hi |=> O_BUSY_N)
        else $error("mode 1 busy late");
    interface_select_hi_busy_a: assert property (
        conv_end && interface_select_hi |=> !O_BUSY_N ##1 O_BUSY_N)
        else $error("mode 2 busy timing wrong");
    interface_select_lo_hold_out_a: assert property (
        !late_load && !early_load |=> $stable(O_RESULT_BUS))
        else $error("output changed without load");
    bus_drive_a: assert property (rd_act |=> O_RESULT_BUS_OE)
        else $error("bus not driven on read");
    offset_load_a: assert property (
        wr_take |=> offset_ff == $past(I_RESULT_BUS))
        else $error("offset not captured");
    nap_follow_a: assert property (I_NAP |=> O_NAP_PD)
        else $error("nap not entered");
    deep_sleep_in_follow_a: assert property (I_DEEP_SLEEP_IN |=> O_STANDBY_PD)
        else $error("standby not entered");
    // reset checks must not be switched off by the reset they watch
    reset_idle_a: assert property (
        @(posedge I_CLK) disable iff (1'b0)
        !I_RST_N |=> state_ff == SAPC_IDLE && O_BUSY_N)
        else $error("reset did not abort");
    reset_quiet_a: assert property (
        @(posedge I_CLK) disable iff (1'b0)
        !I_RST_N |=> !O_HOLD && !O_RESULT_BUS_OE)
        else $error("sampler or bus active in reset");

    // sampler, busy and count through a conversion; no start while powered down
    conv_hold_a: assert property (
        state_ff == SAPC_CONV |-> O_HOLD && !O_BUSY_N)
        else $error("hold or busy dropped inside conversion");
    count_step_a: assert property (
        state_ff == SAPC_CONV && !conv_end |=> state_ff == SAPC_CONV)
        else $error("conversion left before the last count");
    count_range_a: assert property (
        state_ff == SAPC_CONV |-> cnt_ff <= CNT_LAST)
        else $error("conversion count past its end");
    idle_when_down_a: assert property (
        state_ff == SAPC_IDLE && !powered |=> state_ff == SAPC_IDLE)
        else $error("conversion started while powered down");

    // output register, overrange bit, bus and offset
    late_load_a: assert property (
        late_load |=> O_RESULT_BUS == $past(proc_data))
        else $error("mode 1 result not moved out at strobe");
    early_load_a: assert property (
        early_load |=> O_RESULT_BUS == $past(proc_data) && O_BUSY_N)
        else $error("mode 2 result or busy wrong");
    ovr_pair_a: assert property (
        late_load || early_load |=> O_OVERRANGE_BIT == $past(proc_ovr))
        else $error("overrange bit not paired with result");
    bus_release_a: assert property (!rd_act |=> !O_RESULT_BUS_OE)
        else $error("bus driven without read");
    offset_keep_a: assert property (
        !wr_take |=> $stable(offset_ff))
        else $error("offset changed without write");

    // main scenarios
    conv_m1_c: cover property (conv_end && !interface_select_hi);
    conv_m2_c: cover property (early_load);
    read_c: cover property (rd_act);
    write_c: cover property (wr_take);
    late_load_c: cover property (late_load);
endmodule
`default_nettype wire

// >>> sapc_host_bus.sv
`timescale 1ns/10ps
`default_nettype none
// host side of the shared data bus
module sapc_host_bus
    import sapc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_host_oe,
    input wire logic [DATA_W-1:0] i_host_d,
    input wire logic i_dev_oe,
    input wire logic [DATA_W-1:0] i_dev_d,
    output logic [DATA_W-1:0] o_level
);
    logic [DATA_W-1:0] last_ff = '0;
    // ------------------------------------------------------------
    // wire resolution
    // ------------------------------------------------------------
    // no pull on the bus: a floating bus toggles so that luck never passes
    always_comb begin
        if (i_host_oe) begin
            o_level = i_host_d;
        end else if (i_dev_oe) begin
            o_level = i_dev_d;
        end else begin
            o_level = ~last_ff;
        end
    end
    // remember the level so the idle pattern changes every cycle
    always_ff @(posedge i_clk) begin
        last_ff <= o_level;
    end
endmodule
`default_nettype wire

// >>> sar_adc_parallel_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module sar_adc_parallel_control_bench
    import sapc_pkg::*;
;
    localparam int CNT = 4;
    logic clk = 1'b0;
    logic rst_n, sleep, nap, cnv_n, sel_lo, sel_hi, saturate_enable, cs_n, rd_n, wr;
    logic host_oe, oe, ovr, ovr_oe, busy_n, hold, nap_pd, sb_pd;
    logic [DATA_W-1:0] host_d, sar, bus_lvl, dout;
    logic [DATA_W-1:0] raws[5] = '{14'h3FFF, 14'h3FFF, 14'h0005,
        14'h0005, 14'h0100};
    logic [DATA_W-1:0] offs[5] = '{14'h0010, 14'h0010, 14'h3FF0,
        14'h3FF0, 14'h3FF0};
    logic [4:0] clips = 5'h05;
    int fails = 0;
    int num_checks = 0;
    // ------------------------------------------------------------
    // clock, design and host bus
    // ------------------------------------------------------------
    always #4 clk = ~clk;
    sapc_top #(.CONV_CNT(CNT)) u_sapc_top (
        .I_CLK(clk), .I_RST_N(rst_n), .I_DEEP_SLEEP_IN(sleep),
        .I_NAP(nap), .I_CONVERT_STROBE_N(cnv_n),
        .I_INTERFACE_SELECT_LO(sel_lo), .I_INTERFACE_SELECT_HI(sel_hi),
        .I_SATURATE_ENABLE(saturate_enable), .I_CS_N(cs_n), .I_RD_N(rd_n),
        .I_WRITE(wr), .I_RESULT_BUS(bus_lvl), .I_SAR_CODE(sar),
        .O_RESULT_BUS(dout), .O_RESULT_BUS_OE(oe), .O_OVERRANGE_BIT(ovr),
        .O_OVERRANGE_BIT_OE(ovr_oe), .O_BUSY_N(busy_n), .O_HOLD(hold),
        .O_NAP_PD(nap_pd), .O_STANDBY_PD(sb_pd));
    sapc_host_bus u_sapc_host_bus (
        .i_clk(clk), .i_host_oe(host_oe), .i_host_d(host_d),
        .i_dev_oe(oe), .i_dev_d(dout), .o_level(bus_lvl));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // inputs always move 1 ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // {overrange, data}: offset is signed, clipping clears overrange
    function automatic logic [14:0] expect_res(input logic [13:0] raw,
        input logic [13:0] off, input logic cl);
        logic [15:0] s;
        s = {2'h0, raw} + {{2{off[13]}}, off};
        if (s[15:14] == 2'h0) begin
            return {1'b0, s[13:0]};
        end
        if (cl) begin
            return s[15] ? 15'h0000 : 15'h3FFF;
        end
        return {1'b1, s[13:0]};
    endfunction
    task automatic convert(input logic [DATA_W-1:0] raw, input int lat);
        int n;
        sar = raw;
        cnv_n = 1'b0;
        tick(2);
        chk("busy_n", 16'(busy_n), 16'h0000);
        chk("hold", 16'(hold), 16'h0001);
        cnv_n = 1'b1;
        n = 2; // edges seen since the strobe went low
        while (busy_n === 1'b0 && n < 100) begin
            tick(1);
            n++;
        end
        chk("latency", 16'(n), 16'(lat));
        chk("hold end", 16'(hold), 16'h0000);
    endtask
    task automatic rd(input logic [14:0] exp);
        rd_n = 1'b0;
        tick(1);
        chk("oe", 16'({ovr_oe, oe}), 16'h0003);
        chk("bus", 16'({ovr, bus_lvl}), {1'b0, exp});
        rd_n = 1'b1;
        tick(1);
        chk("oe off", 16'({ovr_oe, oe}), 16'h0000);
    endtask
    // host holds the word until the edge that sees the write fall
    task automatic wr_off(input logic [DATA_W-1:0] off);
        host_d = off;
        host_oe = 1'b1;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        tick(1);
        host_oe = 1'b0;
        host_d = ~off;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // whole run is under two hundred cycles; fifteen times that means a hang
    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        give_verdict();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        {sleep, nap, sel_lo, saturate_enable, rd_n, wr, host_oe} = 7'h08;
        {cnv_n, sel_hi, cs_n} = 3'h7;
        host_d = '0;
        sar = '0;
        tick(1);
        cnv_n = 1'b0;
        tick(2);
        chk("rst", 16'({busy_n, hold, oe}), 16'h0004);
        rst_n = 1'b1;
        tick(1);
        cnv_n = 1'b1;
        rd_n = 1'b0;
        tick(2);
        chk("cs gate", 16'(oe), 16'h0000);
        rd_n = 1'b1;
        cs_n = 1'b0; // chip select tied low from here on
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            {sel_hi, sel_lo} = 2'(i + 3);
            convert(14'h0123 + 14'(i),
                ({sel_hi, sel_lo} == SEL_INTERFACE_SELECT_HI) ? CNT + 2 : CNT + 1);
        end
        rd({1'b0, 14'h0126});
        {sel_hi, sel_lo} = 2'h1;
        convert(14'h0AAA, CNT + 1);
        rd({1'b0, 14'h0126});
        convert(14'h0555, CNT + 1);
        rd({1'b0, 14'h0AAA});
        $display("test modes done");
        {sel_hi, sel_lo} = SEL_INTERFACE_SELECT_HI;
        for (int k = 0; k < 5; k++) begin
            wr_off(offs[k]);
            saturate_enable = clips[k];
            convert(raws[k], CNT + 2);
            rd(expect_res(raws[k], offs[k], clips[k]));
        end
        saturate_enable = 1'b0;
        $display("test offset done");
        for (int k = 0; k < 2; k++) begin
            {sleep, nap} = 2'(k + 1);
            tick(2);
            chk("pd", 16'({sb_pd, nap_pd}), 16'(k + 1));
            cnv_n = 1'b0;
            tick(CNT + 3);
            chk("pd busy", 16'(busy_n), 16'h0001);
            cnv_n = 1'b1;
            {sleep, nap} = 2'h0;
            tick(NAP_SETTLE_CYCLES);
        end
        convert(14'h0042, CNT + 2);
        rd(expect_res(14'h0042, 14'h3FF0, 1'b0));
        $display("test power done");
        sar = 14'h1111;
        cnv_n = 1'b0;
        tick(3);
        rst_n = 1'b0;
        tick(3);
        chk("abort", 16'({busy_n, hold, oe}), 16'h0004);
        {cnv_n, rst_n} = 2'h3;
        tick(CNT + 3);
        chk("abort idle", 16'(busy_n), 16'h0001);
        convert(14'h0777, CNT + 2);
        rd(expect_res(14'h0777, OFFSET_RST, 1'b0));
        $display("test abort done");
        give_verdict();
    end
endmodule
`default_nettype wire
